// *** core/tss_pkg.sv ***
// Shared constants and types for the touch sensing sequencer.
`default_nettype none
package tss_pkg;
   // Bus address of the device.
   localparam logic [6:0] DEV_ADDR        = 7'h28;
   // Register offsets.
   localparam logic [7:0] REG_MAIN        = 8'h00;
   localparam logic [7:0] REG_GSTAT       = 8'h02;
   localparam logic [7:0] REG_TOUCH       = 8'h03;
   localparam logic [7:0] REG_DELTA0      = 8'h10;
   localparam logic [7:0] REG_SENS        = 8'h1f;
   localparam logic [7:0] REG_CFG         = 8'h20;
   localparam logic [7:0] REG_EN          = 8'h21;
   localparam logic [7:0] REG_INCFG       = 8'h22;
   localparam logic [7:0] REG_AVG         = 8'h24;
   localparam logic [7:0] REG_CAL         = 8'h26;
   localparam logic [7:0] REG_RECAL       = 8'h2f;
   localparam logic [7:0] REG_THR         = 8'h30;
   localparam logic [7:0] REG_SBY_EN      = 8'h41;
   localparam logic [7:0] REG_PROX_SEL    = 8'h42;
   localparam logic [7:0] REG_PROX_CNT    = 8'h43;
   localparam logic [7:0] REG_BASE0       = 8'h50;
   // Values after reset.
   localparam logic [7:0] RST_SENS        = 8'h2f;
   localparam logic [7:0] RST_CFG         = 8'h20;
   localparam logic [5:0] RST_EN          = 6'h3f;
   localparam logic [7:0] RST_INCFG       = 8'ha4;
   localparam logic [7:0] RST_AVG         = 8'h39;
   localparam logic [7:0] RST_RECAL       = 8'h83;
   localparam logic [7:0] RST_THR         = 8'h40;
   localparam logic [5:0] RST_SBY_EN      = 6'h01;
   // Field positions and number of inputs.
   localparam int         MAIN_SBY_BIT    = 5;
   localparam int         MAIN_DSL_BIT    = 4;
   localparam int         MAIN_INT_BIT    = 0;
   localparam int         CFG_HOLD_EN_BIT = 3;
   localparam int         NCH             = 6;
   // Timing.
   localparam int         CLK_FREQ_HZ     = 125_000_000;
   localparam int         MS_CYCLES       = CLK_FREQ_HZ / 1000;
   localparam int         CAL_TIME_MS     = 200;
   localparam int         HOLD_STEP_MS    = 512;
   localparam int         AUTO_LOG2_MIN   = 3;

   typedef enum {TSS_L_IDLE, TSS_L_ADDR, TSS_L_REGP, TSS_L_WDATA, TSS_L_RDATA} tss_lstate_t;
   typedef enum {TSS_S_GAP, TSS_S_PICK, TSS_S_WAIT} tss_sstate_t;

   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] data;
   } tss_req_t;

   typedef struct packed {
      logic [2:0] ch;
      logic [2:0] samples_log2;
   } tss_meas_t;
endpackage : tss_pkg
`default_nettype wire

// *** core/tss_top.sv ***
// Touch sensing sequencer: bus slave, register file, sensing cycle and recalibration.
// Notes on behaviour
// - Block write: address, register pointer, then any data bytes, each acknowledged.
// - Pointer steps by one after each data byte and wraps from top to zero.
// - Block read: pointer write, repeated start, read address, host nacks last byte.
// - Standby and deep sleep bits pick the state; changes clear stale touches.
// - Fully active state measures every enabled input.
// - Standby measures only its own subset and keeps answering the bus.
// - Deep sleep measures nothing; bus traffic wakes it only until traffic ends.
// - Sensing cycles repeat after a gap of avg_r[1:0] plus one ms ticks, inputs visited first to sixth.
// - Each input has its own enable bit for the sensing cycle.
// - Measurement minus baseline above threshold flags a touch and an alert.
// - Averaging and sampling settings set the sensing cycle duration.
// - Every recalibration reloads the input's baseline.
// - Leaving standby recalibrates inputs off in standby; deep wake recalibrates all.
// - Calibration bit starts a recalibration and clears itself when done.
// - Manual recalibration blocks touches up to its time; a touch restarts it.
// - Automatic recalibration averages recent measurements at a programmable rate.
// - Automatic recalibration runs only while no touch is seen.
// - A set count of negative deltas forces recalibration, touches ignored.
// - Touch held beyond hold limit forces recalibration when enabled.
// - Proximity inputs take one to 128 samples per cycle.
// - The clock line is never held low by the device.
// - A stop condition resets the bus slave for the next transaction.
`default_nettype none
module tss_top
   import tss_pkg::*;
#(
   parameter int MS_TICK_CYCLES = MS_CYCLES
) (
   input  wire logic       CLK_IN,
   input  wire logic       RST_IN,
   input  wire logic       LINK_CLK_IN,
   input  wire logic       SCL_IN,
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE_OUT,
   output logic            MEAS_REQ_OUT,
   output tss_meas_t       MEAS_SEL_OUT,
   input  wire logic       MEAS_DONE_IN,
   input  wire logic [7:0] MEAS_VALUE_IN,
   output logic [5:0]      CAL_ACTIVE_OUT,
   output logic [5:0]      TOUCH_OUT,
   output logic            ALERT_OUT,
   output logic            DEEP_SLEEP_OUT
);
   // Link domain: runs on the free-running oversampling clock.
   logic        lrst_s1, lrst_s2;
   logic        scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
   tss_lstate_t lst_r;
   logic [3:0]  bit_r;
   logic [7:0]  sh_r, ptr_r;
   logic        match_r, rw_r, nack_r, busy_r, oe_r, sda_out_r, req_tgl_r;
   tss_req_t    req_r;
   logic        scl_rise, scl_fall, bus_start, bus_stop;
   logic [7:0]  rdata_r;

   always_ff @(posedge LINK_CLK_IN) begin
      lrst_s1 <= RST_IN;
      lrst_s2 <= lrst_s1;
      scl_s1  <= SCL_IN;
      scl_s2  <= scl_s1;
      scl_s3  <= scl_s2;
      sda_s1  <= SDA_IN;
      sda_s2  <= sda_s1;
      sda_s3  <= sda_s2;
   end

   assign scl_rise  = scl_s2 & ~scl_s3;
   assign scl_fall  = ~scl_s2 & scl_s3;
   assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

   // The read data is requested at least one bus bit before it is loaded, which leaves
   // the handshake ample time to settle rdata_r; fast hosts rely on that margin.
   always_ff @(posedge LINK_CLK_IN) begin
      sda_out_r <= 1'b0;
      if (lrst_s2) begin
         lst_r     <= TSS_L_IDLE;
         bit_r     <= 4'h0;
         sh_r      <= 8'h00;
         ptr_r     <= 8'h00;
         match_r   <= 1'b0;
         rw_r      <= 1'b0;
         nack_r    <= 1'b0;
         busy_r    <= 1'b0;
         oe_r      <= 1'b0;
         req_tgl_r <= 1'b0;
         req_r     <= '0;
      end else if (bus_stop) begin
         lst_r  <= TSS_L_IDLE;
         oe_r   <= 1'b0;
         busy_r <= 1'b0;
      end else if (bus_start) begin
         lst_r <= TSS_L_ADDR;
         // The start's own clock fall wraps the count to zero before the first bit.
         bit_r <= 4'hf;
         oe_r  <= 1'b0;
      end else if (scl_rise && lst_r != TSS_L_IDLE) begin
         if (bit_r < 4'h8 && lst_r != TSS_L_RDATA) begin
            sh_r <= {sh_r[6:0], sda_s2};
         end else if (bit_r == 4'h8 && lst_r == TSS_L_RDATA) begin
            nack_r <= sda_s2;
         end
      end else if (scl_fall && lst_r != TSS_L_IDLE) begin
         if (bit_r == 4'h7) begin
            bit_r <= 4'h8;
            oe_r  <= 1'b1;
            case (lst_r)
               TSS_L_ADDR: begin
                  match_r <= (sh_r[7:1] == DEV_ADDR);
                  rw_r    <= sh_r[0];
                  busy_r  <= (sh_r[7:1] == DEV_ADDR);
                  oe_r    <= (sh_r[7:1] == DEV_ADDR);
                  if (sh_r[7:1] == DEV_ADDR && sh_r[0]) begin
                     req_r     <= '{we: 1'b0, addr: ptr_r, data: 8'h00};
                     req_tgl_r <= ~req_tgl_r;
                  end
               end
               TSS_L_REGP: begin
                  ptr_r <= sh_r;
               end
               TSS_L_WDATA: begin
                  req_r     <= '{we: 1'b1, addr: ptr_r, data: sh_r};
                  req_tgl_r <= ~req_tgl_r;
                  ptr_r     <= ptr_r + 8'h01;
               end
               TSS_L_RDATA: begin
                  oe_r      <= 1'b0;
                  ptr_r     <= ptr_r + 8'h01;
                  req_r     <= '{we: 1'b0, addr: ptr_r + 8'h01, data: 8'h00};
                  req_tgl_r <= ~req_tgl_r;
               end
               default: begin
                  oe_r <= 1'b0;
               end
            endcase
         end else if (bit_r == 4'h8) begin
            bit_r <= 4'h0;
            oe_r  <= 1'b0;
            case (lst_r)
               TSS_L_ADDR: begin
                  if (!match_r) begin
                     lst_r <= TSS_L_IDLE;
                  end else if (rw_r) begin
                     lst_r <= TSS_L_RDATA;
                     sh_r  <= rdata_r;
                     oe_r  <= ~rdata_r[7];
                  end else begin
                     lst_r <= TSS_L_REGP;
                  end
               end
               TSS_L_REGP: begin
                  lst_r <= TSS_L_WDATA;
               end
               TSS_L_RDATA: begin
                  if (nack_r) begin
                     lst_r <= TSS_L_IDLE;
                  end else begin
                     sh_r <= rdata_r;
                     oe_r <= ~rdata_r[7];
                  end
               end
               default: begin
                  lst_r <= lst_r;
               end
            endcase
         end else begin
            bit_r <= bit_r + 4'h1;
            if (lst_r == TSS_L_RDATA) begin
               sh_r <= {sh_r[6:0], 1'b0};
               oe_r <= ~sh_r[6];
            end
         end
      end
   end

   assign SDA_OUT    = sda_out_r;
   assign SDA_OE_OUT = oe_r;

   // Core domain: handshake from link, register file and sensing.
   logic        tgl_s1, tgl_s2, tgl_s3, busy_s1, busy_s2;
   logic        req_pulse, wr_hit;
   logic        sby_r, dsl_r, sby_prev_r, dsl_prev_r, int_r;
   logic [7:0]  sens_r, cfg_r, incfg_r, avg_r, recal_r, thr_r;
   logic [5:0]  en_r, sby_en_r, prox_sel_r, cal_r, touch_r, pend_r, active;
   logic [2:0]  prox_cnt_r;
   logic [7:0]  cal_ms_r;
   logic        cal_bad_r;
   logic [7:0]  rd_mux;
   logic [16:0] ms_cnt_r;
   logic        ms_tick;
   logic [7:0]  base_r [NCH];
   logic [7:0]  delta_r [NCH];
   logic [13:0] sum_r [NCH];
   logic [6:0]  cnt_r [NCH];
   logic [3:0]  neg_r [NCH];
   logic [15:0] hold_r [NCH];

   always_ff @(posedge CLK_IN) begin
      tgl_s1  <= req_tgl_r;
      tgl_s2  <= tgl_s1;
      tgl_s3  <= tgl_s2;
      busy_s1 <= busy_r;
      busy_s2 <= busy_s1;
   end

   assign req_pulse = tgl_s2 ^ tgl_s3;
   assign wr_hit    = req_pulse & req_r.we;

   always_ff @(posedge CLK_IN) begin
      if (RST_IN || ms_tick) begin
         ms_cnt_r <= 17'h00000;
      end else begin
         ms_cnt_r <= ms_cnt_r + 17'h00001;
      end
   end
   assign ms_tick = (ms_cnt_r == 17'(MS_TICK_CYCLES - 1));

   assign active = dsl_r ? 6'h00 : (sby_r ? sby_en_r : en_r);

   always_comb begin
      rd_mux = 8'h00;
      case (req_r.addr)
         REG_MAIN:     rd_mux = {2'h0, sby_r, dsl_r, 3'h0, int_r};
         REG_GSTAT:    rd_mux = {6'h00, |cal_r, |touch_r};
         REG_TOUCH:    rd_mux = {2'h0, touch_r};
         REG_SENS:     rd_mux = sens_r;
         REG_CFG:      rd_mux = cfg_r;
         REG_EN:       rd_mux = {2'h0, en_r};
         REG_INCFG:    rd_mux = incfg_r;
         REG_AVG:      rd_mux = avg_r;
         REG_CAL:      rd_mux = {2'h0, cal_r};
         REG_RECAL:    rd_mux = recal_r;
         REG_THR:      rd_mux = thr_r;
         REG_SBY_EN:   rd_mux = {2'h0, sby_en_r};
         REG_PROX_SEL: rd_mux = {2'h0, prox_sel_r};
         REG_PROX_CNT: rd_mux = {5'h00, prox_cnt_r};
         default: begin
            if (req_r.addr >= REG_DELTA0 && req_r.addr < REG_DELTA0 + 8'(NCH)) begin
               rd_mux = delta_r[req_r.addr[2:0]];
            end else if (req_r.addr >= REG_BASE0 && req_r.addr < REG_BASE0 + 8'(NCH)) begin
               rd_mux = base_r[req_r.addr[2:0]];
            end
         end
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         rdata_r    <= 8'h00;
         sby_r      <= 1'b0;
         dsl_r      <= 1'b0;
         sens_r     <= RST_SENS;
         cfg_r      <= RST_CFG;
         en_r       <= RST_EN;
         incfg_r    <= RST_INCFG;
         avg_r      <= RST_AVG;
         recal_r    <= RST_RECAL;
         thr_r      <= RST_THR;
         sby_en_r   <= RST_SBY_EN;
         prox_sel_r <= 6'h00;
         prox_cnt_r <= 3'h0;
      end else if (req_pulse && !req_r.we) begin
         rdata_r <= rd_mux;
      end else if (wr_hit) begin
         case (req_r.addr)
            REG_MAIN: begin
               sby_r <= req_r.data[MAIN_SBY_BIT];
               dsl_r <= req_r.data[MAIN_DSL_BIT];
            end
            REG_SENS:     sens_r     <= req_r.data;
            REG_CFG:      cfg_r      <= req_r.data;
            REG_EN:       en_r       <= req_r.data[5:0];
            REG_INCFG:    incfg_r    <= req_r.data;
            REG_AVG:      avg_r      <= req_r.data;
            REG_RECAL:    recal_r    <= req_r.data;
            REG_THR:      thr_r      <= req_r.data;
            REG_SBY_EN:   sby_en_r   <= req_r.data[5:0];
            REG_PROX_SEL: prox_sel_r <= req_r.data[5:0];
            REG_PROX_CNT: prox_cnt_r <= req_r.data[2:0];
            default:      rdata_r    <= rdata_r;
         endcase
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         cal_r    <= 6'h00;
         cal_ms_r <= 8'h00;
      end else if (wr_hit && req_r.addr == REG_CAL && req_r.data[5:0] != 6'h00) begin
         cal_r    <= cal_r | req_r.data[5:0];
         cal_ms_r <= 8'h00;
      end else if (cal_r != 6'h00) begin
         if (cal_bad_r) begin
            cal_ms_r <= 8'h00;
         end else if (ms_tick && cal_ms_r == 8'(CAL_TIME_MS - 1)) begin
            cal_r    <= 6'h00;
            cal_ms_r <= 8'h00;
         end else if (ms_tick) begin
            cal_ms_r <= cal_ms_r + 8'h01;
         end
      end
   end

   // Sensing cycle.
   tss_sstate_t sst_r;
   logic [2:0]  ch_r;
   logic [7:0]  gap_r;
   logic        req_o_r;
   logic [8:0]  dlt;
   logic        touched;
   logic [2:0]  win_log2;

   assign dlt      = {1'b0, MEAS_VALUE_IN} - {1'b0, base_r[ch_r]};
   assign touched  = ~dlt[8] & (dlt[7:0] > thr_r);
   assign win_log2 = 3'(AUTO_LOG2_MIN) + {1'b0, recal_r[1:0]};

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         sst_r        <= TSS_S_GAP;
         ch_r         <= 3'h0;
         gap_r        <= 8'h00;
         req_o_r      <= 1'b0;
         MEAS_SEL_OUT <= '0;
      end else begin
         req_o_r <= 1'b0;
         case (sst_r)
            TSS_S_GAP: begin
               if (ms_tick) begin
                  gap_r <= gap_r + 8'h01;
               end
               if (gap_r > {6'h00, avg_r[1:0]}) begin
                  gap_r <= 8'h00;
                  ch_r  <= 3'h0;
                  sst_r <= TSS_S_PICK;
               end
            end
            TSS_S_PICK: begin
               if (active[ch_r]) begin
                  req_o_r      <= 1'b1;
                  MEAS_SEL_OUT <= '{ch: ch_r, samples_log2:
                                    prox_sel_r[ch_r] ? prox_cnt_r : avg_r[6:4]};
                  sst_r        <= TSS_S_WAIT;
               end else if (ch_r == 3'(NCH - 1)) begin
                  sst_r <= TSS_S_GAP;
               end else begin
                  ch_r <= ch_r + 3'h1;
               end
            end
            TSS_S_WAIT: begin
               if (MEAS_DONE_IN) begin
                  sst_r <= (ch_r == 3'(NCH - 1)) ? TSS_S_GAP : TSS_S_PICK;
                  ch_r  <= (ch_r == 3'(NCH - 1)) ? ch_r : ch_r + 3'h1;
               end
            end
            default: sst_r <= TSS_S_GAP;
         endcase
      end
   end

   // Per-input baseline, touch and recalibration state.
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         sby_prev_r <= 1'b0;
         dsl_prev_r <= 1'b0;
         int_r      <= 1'b0;
         touch_r    <= 6'h00;
         pend_r     <= 6'h00;
         cal_bad_r  <= 1'b0;
         for (int i = 0; i < NCH; i++) begin
            base_r[i]  <= 8'h00;
            delta_r[i] <= 8'h00;
            sum_r[i]   <= 14'h0000;
            cnt_r[i]   <= 7'h00;
            neg_r[i]   <= 4'h0;
            hold_r[i]  <= 16'h0000;
         end
      end else begin
         sby_prev_r <= sby_r;
         dsl_prev_r <= dsl_r;
         cal_bad_r  <= 1'b0;
         if (wr_hit && req_r.addr == REG_MAIN && !req_r.data[MAIN_INT_BIT]) begin
            int_r <= 1'b0;
         end
         for (int i = 0; i < NCH; i++) begin
            if (!touch_r[i]) begin
               hold_r[i] <= 16'h0000;
            end else if (ms_tick) begin
               hold_r[i] <= hold_r[i] + 16'h0001;
            end
            if (cfg_r[CFG_HOLD_EN_BIT] && touch_r[i] &&
                hold_r[i] >= 16'(({12'h000, incfg_r[7:4]} + 16'h0001) * HOLD_STEP_MS)) begin
               pend_r[i]  <= 1'b1;
               touch_r[i] <= 1'b0;
               hold_r[i]  <= 16'h0000;
            end
         end
         if (sst_r == TSS_S_WAIT && MEAS_DONE_IN) begin
            delta_r[ch_r] <= dlt[8] ? 8'h00 : dlt[7:0];
            if (pend_r[ch_r]) begin
               base_r[ch_r]  <= MEAS_VALUE_IN;
               pend_r[ch_r]  <= 1'b0;
               touch_r[ch_r] <= 1'b0;
               sum_r[ch_r]   <= 14'h0000;
               cnt_r[ch_r]   <= 7'h00;
            end else if (cal_r[ch_r]) begin
               base_r[ch_r]  <= MEAS_VALUE_IN;
               touch_r[ch_r] <= 1'b0;
               cal_bad_r     <= touched;
            end else begin
               touch_r[ch_r] <= touched;
               if (touched && !touch_r[ch_r]) begin
                  int_r <= 1'b1;
               end
               if (touched) begin
                  sum_r[ch_r] <= 14'h0000;
                  cnt_r[ch_r] <= 7'h00;
               end else if (cnt_r[ch_r] == 7'((1 << win_log2) - 1)) begin
                  base_r[ch_r] <= 8'((sum_r[ch_r] + {6'h00, MEAS_VALUE_IN}) >> win_log2);
                  sum_r[ch_r]  <= 14'h0000;
                  cnt_r[ch_r]  <= 7'h00;
               end else begin
                  sum_r[ch_r] <= sum_r[ch_r] + {6'h00, MEAS_VALUE_IN};
                  cnt_r[ch_r] <= cnt_r[ch_r] + 7'h01;
               end
               if (!dlt[8]) begin
                  neg_r[ch_r] <= 4'h0;
               end else if (recal_r[7:4] != 4'h0 && neg_r[ch_r] + 4'h1 >= recal_r[7:4]) begin
                  pend_r[ch_r] <= 1'b1;
                  neg_r[ch_r]  <= 4'h0;
               end else begin
                  neg_r[ch_r] <= neg_r[ch_r] + 4'h1;
               end
            end
         end
         // State change clears touches of inactive inputs.
         if (sby_prev_r != sby_r || dsl_prev_r != dsl_r) begin
            touch_r <= touch_r & active;
            int_r   <= 1'b0;
         end
         // Recalibrate on standby exit and deep wake.
         if (dsl_prev_r && !dsl_r) begin
            pend_r <= 6'h3f;
         end else if (sby_prev_r && !sby_r) begin
            pend_r <= pend_r | (en_r & ~sby_en_r);
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         CAL_ACTIVE_OUT <= 6'h00;
         TOUCH_OUT      <= 6'h00;
         ALERT_OUT      <= 1'b0;
         DEEP_SLEEP_OUT <= 1'b0;
      end else begin
         CAL_ACTIVE_OUT <= cal_r;
         TOUCH_OUT      <= touch_r;
         ALERT_OUT      <= int_r;
         DEEP_SLEEP_OUT <= dsl_r & ~busy_s2;
      end
   end
   assign MEAS_REQ_OUT = req_o_r;
endmodule : tss_top
`default_nettype wire

// *** verif/tss_top_asserts.sv ***
// Port checker for the touch sensing sequencer.
`default_nettype none
module tss_top_asserts
   import tss_pkg::*;
#(
   parameter int MS_TICK_CYCLES = 20
) (
   input wire logic       CLK_IN,
   input wire logic       RST_IN,
   input wire logic       LINK_CLK_IN,
   input wire logic       SCL_IN,
   input wire logic       SDA_OUT,
   input wire logic       SDA_OE_OUT,
   input wire logic       MEAS_REQ_OUT,
   input wire tss_meas_t  MEAS_SEL_OUT,
   input wire logic       MEAS_DONE_IN,
   input wire logic [5:0] CAL_ACTIVE_OUT,
   input wire logic [5:0] TOUCH_OUT,
   input wire logic       ALERT_OUT,
   input wire logic       DEEP_SLEEP_OUT
);
   logic [2:0] last_r;
   int         gap_r;
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) last_r <= 3'h7;
      else if (MEAS_REQ_OUT) last_r <= MEAS_SEL_OUT.ch;
   end
   // Saturating so that a long gap does not wrap into a short one.
   always_ff @(posedge CLK_IN) begin
      if (RST_IN || MEAS_REQ_OUT) gap_r <= 0;
      else if (gap_r < MS_TICK_CYCLES) gap_r <= gap_r + 1;
   end
   sequence s_new_touch;
      (TOUCH_OUT & ~$past(TOUCH_OUT)) != 6'h00;
   endsequence
   sequence s_new_round;
      MEAS_REQ_OUT && last_r != 3'h7 && MEAS_SEL_OUT.ch <= last_r;
   endsequence
   a_req_one_cycle: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      MEAS_REQ_OUT |=> !MEAS_REQ_OUT) else $error("request too long");
   a_channel_range: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      MEAS_REQ_OUT |-> MEAS_SEL_OUT.ch < 3'h6) else $error("bad channel");
   a_round_gap: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      s_new_round |-> gap_r >= MS_TICK_CYCLES) else $error("order or gap wrong");
   a_deep_idle: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      $past(DEEP_SLEEP_OUT) && DEEP_SLEEP_OUT |-> !MEAS_REQ_OUT) else $error("deep measure");
   a_sda_open_drain: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !SDA_OUT) else $error("data driven high");
   a_touch_cause: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      s_new_touch |-> $past(MEAS_DONE_IN, 2)) else $error("touch without result");
   a_touch_alert: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      s_new_touch |-> ALERT_OUT) else $error("touch without alert");
   a_cal_blocks: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (TOUCH_OUT & ~$past(TOUCH_OUT) & $past(CAL_ACTIVE_OUT)) == 6'h00) else $error("cal touch");
   a_sda_scl_low: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
      $changed(SDA_OE_OUT) |-> !SCL_IN) else $error("data moved in clock high");
endmodule : tss_top_asserts
bind tss_top tss_top_asserts #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) i_tss_top_asserts (
   .CLK_IN(CLK_IN), .RST_IN(RST_IN), .LINK_CLK_IN(LINK_CLK_IN), .SCL_IN(SCL_IN),
   .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .MEAS_REQ_OUT(MEAS_REQ_OUT),
   .MEAS_SEL_OUT(MEAS_SEL_OUT), .MEAS_DONE_IN(MEAS_DONE_IN), .CAL_ACTIVE_OUT(CAL_ACTIVE_OUT),
   .TOUCH_OUT(TOUCH_OUT), .ALERT_OUT(ALERT_OUT), .DEEP_SLEEP_OUT(DEEP_SLEEP_OUT));
`default_nettype wire

// *** verif/tss_host.sv ***
// Host controller model on the two-wire bus.
`default_nettype none
module tss_host (
   output logic      scl_out,
   output logic      sda_low_out,
   input  wire logic sda_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // Clock stands high between frames; the host never stretches it.
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic start;
      sda_low_out = 1'b0;
      #375 scl_out = 1'b1;
      #750 sda_low_out = 1'b1;
      #750 scl_out = 1'b0;
      #375;
   endtask : start
   task automatic stop;
      sda_low_out = 1'b1;
      #375 scl_out = 1'b1;
      #750 sda_low_out = 1'b0;
      #750;
   endtask : stop
   task automatic xbit(input logic b, output logic r);
      sda_low_out = !b;
      #375 scl_out = 1'b1;
      #375 r = sda_in;
      #375 scl_out = 1'b0;
      #375;
   endtask : xbit
   // byte MSB first, then the acknowledge bit.
   task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
      for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
      xbit(a, r);
   endtask : xbyte
endmodule : tss_host
`default_nettype wire

// *** verif/tss_top_tb.sv ***
// Self-checking bench of the touch sensing sequencer.
`default_nettype none
module tss_top_tb;
   import tss_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst = 1'b1, lclk = 1'b0, scl, host_low, sda_o, sda_oe, req, done = 1'b0;
   logic alert, deep;
   logic [5:0] cal, touch;
   tss_meas_t sel;
   logic [7:0] vals [6] = '{default: 8'h00};
   logic [2:0] fe_ch = 3'h0;
   logic [2:0] seen [$];
   int fe_cnt = 0, n_mismatch = 0, n_checks = 0, cyc = 0;
   wire sda = !(host_low || (sda_oe && !sda_o));
   always #4 clk = ~clk;
   initial begin
      #3.1;
      forever #62.5 lclk = ~lclk;
   end
   tss_host i_tss_host (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda));
   tss_top #(.MS_TICK_CYCLES(20)) i_tss_top (.CLK_IN(clk), .RST_IN(rst), .LINK_CLK_IN(lclk),
      .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .MEAS_REQ_OUT(req),
      .MEAS_SEL_OUT(sel), .MEAS_DONE_IN(done), .MEAS_VALUE_IN(vals[fe_ch]),
      .CAL_ACTIVE_OUT(cal), .TOUCH_OUT(touch), .ALERT_OUT(alert), .DEEP_SLEEP_OUT(deep));
   // Front end answers each request three cycles later.
   always @(negedge clk) begin
      done <= (fe_cnt == 1);
      fe_cnt <= req ? 3 : (fe_cnt > 0 ? fe_cnt - 1 : 0);
      if (req) fe_ch <= sel.ch;
      if (req) seen.push_back(sel.ch);
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         n_mismatch++;
         test_done();
      end
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic head(input logic [7:0] p);
      logic [7:0] q;
      logic r;
      i_tss_host.start();
      i_tss_host.xbyte({DEV_ADDR, 1'b0}, 1'b1, q, r);
      chk("addr ack", 8'h00, {7'h0, r});
      i_tss_host.xbyte(p, 1'b1, q, r);
      chk("pointer ack", 8'h00, {7'h0, r});
   endtask : head
   task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
      logic [7:0] q;
      logic r;
      head(p);
      foreach (d[i]) begin
         i_tss_host.xbyte(d[i], 1'b1, q, r);
         chk("data ack", 8'h00, {7'h0, r});
      end
      i_tss_host.stop();
   endtask : wr
   task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
      logic [7:0] q;
      logic r;
      head(p);
      i_tss_host.start();
      i_tss_host.xbyte({DEV_ADDR, 1'b1}, 1'b1, q, r);
      chk("read addr ack", 8'h00, {7'h0, r});
      foreach (e[i]) begin
         i_tss_host.xbyte(8'hff, i == e.size() - 1, q, r);
         chk("read data", e[i], q);
      end
      i_tss_host.stop();
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle
   initial begin
      idle(64);
      rst = 1'b0;
      idle(100);
      chk("touch after reset", 8'h00, {2'b00, touch});
      rd(REG_CFG, '{RST_CFG, {2'b00, RST_EN}, RST_INCFG});
      $display("test reset values done");
      wr(REG_EN, '{8'h15});
      idle(200);
      seen.delete();
      idle(300);
      chk("requests seen", 8'h01, {7'h0, seen.size() > 2});
      for (int k = 1; k < seen.size(); k++) begin
         chk("next channel", seen[k-1] == 3'h4 ? 8'h00 : seen[k-1] + 8'h02, seen[k]);
      end
      $display("test sensing order done");
      vals[2] = 8'h30;
      wr(REG_CAL, '{8'h04});
      chk("cal active", 8'h04, {2'b00, cal});
      for (int k = 0; k < 9000 && cal !== 6'h00; k++) idle(1);
      chk("cal cleared", 8'h00, {2'b00, cal});
      rd(REG_BASE0 + 8'h02, '{8'h30});
      vals[2] = 8'h71;
      vals[1] = 8'hff;
      idle(300);
      chk("touch flags", 8'h04, {2'b00, touch});
      chk("alert", 8'h01, {7'h0, alert});
      $display("test calibrate and touch done");
      wr(8'hff, '{8'h00, 8'h20});
      idle(200);
      chk("touch in standby", 8'h00, {2'b00, touch});
      chk("alert in standby", 8'h00, {7'h0, alert});
      seen.delete();
      idle(300);
      chk("standby requests", 8'h01, {7'h0, seen.size() > 0});
      foreach (seen[k]) chk("standby channel", 8'h00, {5'h0, seen[k]});
      chk("sample count", {5'h0, RST_AVG[6:4]}, {5'h0, sel.samples_log2});
      rd(REG_MAIN, '{8'h20});
      $display("test standby done");
      wr(REG_MAIN, '{8'h10});
      idle(100);
      chk("deep sleep", 8'h01, {7'h0, deep});
      seen.delete();
      idle(300);
      chk("deep requests", 8'h00, seen.size());
      $display("test deep sleep done");
      test_done();
   end
endmodule : tss_top_tb
`default_nettype wire
